//--- spi_fifo_event_pkg.sv
package spi_fifo_event_pkg;

   // Buffer geometry, fixed at build
   localparam int          BUFFER_DEPTH = 16;
   localparam int          COUNT_W      = 6;
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          REG_W        = 16;
   localparam int          BAUD_W       = 16;

   localparam logic [COUNT_W-1:0] DEPTH_VAL = COUNT_W'(BUFFER_DEPTH);
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_LEVEL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_EVT_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_WM     = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_BAUD   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h14;

   // Buffer-level status fields
   localparam int RX_COUNT_LSB = 8;
   localparam int TX_COUNT_LSB = 0;

   // Event enable and flag bit positions (shared layout)
   localparam int FRAME_ERR_BIT  = 12;
   localparam int ACTIVITY_BIT   = 11;
   localparam int UNDERRUN_BIT   = 8;
   localparam int SHIFT_EMPTY_BIT = 7;
   localparam int OVERFLOW_BIT   = 6;
   localparam int RX_EMPTY_BIT   = 5;
   localparam int TX_EMPTY_BIT   = 3;
   localparam int TX_FULL_BIT    = 1;
   localparam int RX_FULL_BIT    = 0;
   localparam logic [REG_W-1:0] EVT_EN_MASK = 16'h19eb;

   // Watermark register fields
   localparam int RX_WM_EN_BIT = 15;
   localparam int RX_WM_LSB    = 8;
   localparam int TX_WM_EN_BIT = 7;
   localparam int TX_WM_LSB    = 0;

   // Control register bits
   localparam int CTRL_PORT_EN_BIT  = 0;
   localparam int CTRL_UR_IGNORE_BIT = 1;

   // Implemented count bits and watermark level bits per depth
   localparam logic [COUNT_W-1:0] COUNT_IMPL = {BUFFER_DEPTH >= 32, BUFFER_DEPTH >= 16,
                                                BUFFER_DEPTH >= 8, 3'h7};
   localparam logic [COUNT_W-1:0] WM_IMPL    = {1'b1, BUFFER_DEPTH >= 32, BUFFER_DEPTH >= 16,
                                                BUFFER_DEPTH >= 8, 2'h3};

   localparam logic [REG_W-1:0] REG_ZERO  = 16'h0000;
   localparam logic [BAUD_W-1:0] BAUD_ZERO = 16'h0000;

   // Events and levels from the shift engine, same clock
   typedef struct packed {
      logic rx_word_done;
      logic rx_word_read;
      logic tx_word_write;
      logic tx_word_load;
      logic frame_error;
      logic port_busy;
      logic tx_underrun;
      logic shifter_empty;
   } engine_evt_s;

endpackage

//--- spi_fifo_event_logic.sv
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Receive count at level bits 13..8
// - Transmit count at level bits 5..0
// - Upper count bits exist only deep enough
// - Bit 12 gates frame error event
// - Bit 11 gates busy activity event
// - Bit 8 gates transmit underrun event
// - Bit 7 gates shifter empty event
// - Bit 6 gates receive overflow event
// - Bit 5 gates receive empty event
// - Bit 3 gates transmit empty event
// - Bit 1 gates transmit full event
// - Bit 0 gates receive full event
// - Receive watermark fires when level <= count
// - Transmit watermark fires when level equals count
// - Level above depth never matches
// - Level bits 4..2 exist only deep enough, bit 5 always
// - Serial clock is bus clock over 2(div+1)
// - Unimplemented bits read zero, reset zero
// - Empty at zero count, full at top
// - Overflow when word arrives into full buffer
// - Underrun cleared when disabled, live when ignored
module spi_fifo_event_logic (
   input  wire logic                                   clk_sys,
   input  wire logic                                   resetn,
   input  wire logic [spi_fifo_event_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                                   avs_read,
   input  wire logic                                   avs_write,
   input  wire logic [spi_fifo_event_pkg::DATA_W-1:0]  avs_writedata,
   output logic      [spi_fifo_event_pkg::DATA_W-1:0]  avs_readdata,
   output logic                                        avs_waitrequest,
   input  wire spi_fifo_event_pkg::engine_evt_s        engine_evt,
   output logic                                        irq,
   output logic                                        serial_clk,
   output logic                                        port_enable,
   output logic                                        underrun_ignore
);
   import spi_fifo_event_pkg::*;

   logic [COUNT_W-1:0] rx_element_count_q;
   logic [COUNT_W-1:0] tx_element_count_q;
   logic [REG_W-1:0]   event_enable_q;
   logic [REG_W-1:0]   watermark_q;
   logic [BAUD_W-1:0]  baud_divider_q;
   logic [BAUD_W-1:0]  baud_cnt_q;
   logic               serial_clk_q;
   logic               port_enable_q;
   logic               underrun_ignore_q;
   logic               frame_error_flag_q;
   logic               tx_underrun_flag_q;
   logic               rx_overflow_flag_q;
   logic               irq_q;
   logic               wait_q;
   logic [DATA_W-1:0]  rdata_q;

   logic               bus_req;
   logic               bus_wr;
   logic [REG_W-1:0]   wdata;
   logic               rx_empty_flag;
   logic               rx_full_flag;
   logic               tx_empty_flag;
   logic               tx_full_flag;
   logic [REG_W-1:0]   flags;
   logic [REG_W-1:0]   level_status;
   logic [COUNT_W-1:0] rx_watermark_level;
   logic [COUNT_W-1:0] tx_watermark_level;
   logic               rx_wm_match;
   logic               tx_wm_match;
   logic [REG_W-1:0]   rd_mux;

   // One term per enabled condition, kept apart so each rule has its own gate
   logic               frame_error_event;
   logic               activity_event;
   logic               underrun_event;
   logic               shifter_empty_event;
   logic               overflow_event;
   logic               rx_empty_event;
   logic               tx_empty_event;
   logic               tx_full_event;
   logic               rx_full_event;
   logic               any_event;
   logic               rx_wm_enabled;
   logic               tx_wm_enabled;
   logic               rx_wm_valid;
   logic               tx_wm_valid;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait cycle, then a single acknowledge cycle
   assign bus_req = avs_read | avs_write;
   assign bus_wr  = avs_write & ~wait_q;
   assign wdata   = avs_writedata[REG_W-1:0];

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wait_q <= 1'b1;
      end else if (bus_req && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_comb begin
      case (avs_address)
         OFF_LEVEL:  rd_mux = level_status;
         OFF_EVT_EN: rd_mux = event_enable_q;
         OFF_WM:     rd_mux = watermark_q;
         OFF_BAUD:   rd_mux = baud_divider_q;
         OFF_CTRL:   rd_mux = {14'h0000, underrun_ignore_q, port_enable_q};
         OFF_FLAGS:  rd_mux = flags;
         default:    rd_mux = REG_ZERO;
      endcase
   end

   // Data is sampled one cycle before the acknowledge edge
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read && wait_q) begin
         rdata_q <= {16'h0000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         event_enable_q <= REG_ZERO;
      end else if (bus_wr && avs_address == OFF_EVT_EN) begin
         event_enable_q <= wdata & EVT_EN_MASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         watermark_q <= REG_ZERO;
      end else if (bus_wr && avs_address == OFF_WM) begin
         watermark_q <= REG_ZERO;
         watermark_q[RX_WM_EN_BIT] <= wdata[RX_WM_EN_BIT];
         watermark_q[TX_WM_EN_BIT] <= wdata[TX_WM_EN_BIT];
         watermark_q[RX_WM_LSB +: COUNT_W] <= wdata[RX_WM_LSB +: COUNT_W] & WM_IMPL;
         watermark_q[TX_WM_LSB +: COUNT_W] <= wdata[TX_WM_LSB +: COUNT_W] & WM_IMPL;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         baud_divider_q <= BAUD_ZERO;
      end else if (bus_wr && avs_address == OFF_BAUD) begin
         baud_divider_q <= wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_enable_q     <= 1'b0;
         underrun_ignore_q <= 1'b0;
      end else if (bus_wr && avs_address == OFF_CTRL) begin
         port_enable_q     <= wdata[CTRL_PORT_EN_BIT];
         underrun_ignore_q <= wdata[CTRL_UR_IGNORE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Element counts; pushes into a full buffer and pops from an empty one are dropped
   always_ff @(posedge clk_sys) begin
      if (!resetn || !port_enable_q) begin
         rx_element_count_q <= COUNT_ZERO;
      end else begin
         case ({engine_evt.rx_word_done && !rx_full_flag, engine_evt.rx_word_read && !rx_empty_flag})
            2'b10:   rx_element_count_q <= rx_element_count_q + 6'h01;
            2'b01:   rx_element_count_q <= rx_element_count_q - 6'h01;
            default: rx_element_count_q <= rx_element_count_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !port_enable_q) begin
         tx_element_count_q <= COUNT_ZERO;
      end else begin
         case ({engine_evt.tx_word_write && !tx_full_flag, engine_evt.tx_word_load && !tx_empty_flag})
            2'b10:   tx_element_count_q <= tx_element_count_q + 6'h01;
            2'b01:   tx_element_count_q <= tx_element_count_q - 6'h01;
            default: tx_element_count_q <= tx_element_count_q;
         endcase
      end
   end

   // Full means the count has reached the configured depth
   assign rx_empty_flag = (rx_element_count_q == COUNT_ZERO);
   assign rx_full_flag  = (rx_element_count_q == DEPTH_VAL);
   assign tx_empty_flag = (tx_element_count_q == COUNT_ZERO);
   assign tx_full_flag  = (tx_element_count_q == DEPTH_VAL);

   always_comb begin
      level_status = REG_ZERO;
      level_status[RX_COUNT_LSB +: COUNT_W] = rx_element_count_q & COUNT_IMPL;
      level_status[TX_COUNT_LSB +: COUNT_W] = tx_element_count_q & COUNT_IMPL;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags, underrun only while not ignored; a set in the clearing cycle wins
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_overflow_flag_q <= 1'b0;
      end else if (engine_evt.rx_word_done && rx_full_flag) begin
         rx_overflow_flag_q <= 1'b1;
      end else if (bus_wr && avs_address == OFF_FLAGS && wdata[OVERFLOW_BIT]) begin
         rx_overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         frame_error_flag_q <= 1'b0;
      end else if (engine_evt.frame_error) begin
         frame_error_flag_q <= 1'b1;
      end else if (bus_wr && avs_address == OFF_FLAGS && wdata[FRAME_ERR_BIT]) begin
         frame_error_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn || !port_enable_q) begin
         tx_underrun_flag_q <= 1'b0;
      end else if (underrun_ignore_q) begin
         tx_underrun_flag_q <= engine_evt.tx_underrun;
      end else if (engine_evt.tx_underrun) begin
         tx_underrun_flag_q <= 1'b1;
      end else if (bus_wr && avs_address == OFF_FLAGS && wdata[UNDERRUN_BIT]) begin
         tx_underrun_flag_q <= 1'b0;
      end
   end

   always_comb begin
      flags = REG_ZERO;
      flags[FRAME_ERR_BIT]   = frame_error_flag_q;
      flags[ACTIVITY_BIT]    = engine_evt.port_busy;
      flags[UNDERRUN_BIT]    = tx_underrun_flag_q;
      flags[SHIFT_EMPTY_BIT] = engine_evt.shifter_empty;
      flags[OVERFLOW_BIT]    = rx_overflow_flag_q;
      flags[RX_EMPTY_BIT]    = rx_empty_flag;
      flags[TX_EMPTY_BIT]    = tx_empty_flag;
      flags[TX_FULL_BIT]     = tx_full_flag;
      flags[RX_FULL_BIT]     = rx_full_flag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watermarks and interrupt request
   assign rx_watermark_level = watermark_q[RX_WM_LSB +: COUNT_W];
   assign tx_watermark_level = watermark_q[TX_WM_LSB +: COUNT_W];

   assign rx_wm_enabled = watermark_q[RX_WM_EN_BIT];
   assign tx_wm_enabled = watermark_q[TX_WM_EN_BIT];

   // A level above the depth could never be reached, so it is refused outright
   assign rx_wm_valid = (rx_watermark_level <= DEPTH_VAL);
   assign tx_wm_valid = (tx_watermark_level <= DEPTH_VAL);

   // Receive fires at or above its level, transmit only on an exact hit
   assign rx_wm_match = rx_wm_enabled && rx_wm_valid &&
                        (rx_watermark_level <= rx_element_count_q);
   assign tx_wm_match = tx_wm_enabled && tx_wm_valid &&
                        (tx_watermark_level == tx_element_count_q);

   // Enable and flag share one layout, so each gate is a single AND
   assign frame_error_event   = flags[FRAME_ERR_BIT] & event_enable_q[FRAME_ERR_BIT];
   assign activity_event      = flags[ACTIVITY_BIT] & event_enable_q[ACTIVITY_BIT];
   assign underrun_event      = flags[UNDERRUN_BIT] & event_enable_q[UNDERRUN_BIT];
   assign shifter_empty_event = flags[SHIFT_EMPTY_BIT] & event_enable_q[SHIFT_EMPTY_BIT];
   assign overflow_event      = flags[OVERFLOW_BIT] & event_enable_q[OVERFLOW_BIT];
   assign rx_empty_event      = flags[RX_EMPTY_BIT] & event_enable_q[RX_EMPTY_BIT];
   assign tx_empty_event      = flags[TX_EMPTY_BIT] & event_enable_q[TX_EMPTY_BIT];
   assign tx_full_event       = flags[TX_FULL_BIT] & event_enable_q[TX_FULL_BIT];
   assign rx_full_event       = flags[RX_FULL_BIT] & event_enable_q[RX_FULL_BIT];

   assign any_event = frame_error_event | activity_event | underrun_event |
                      shifter_empty_event | overflow_event | rx_empty_event |
                      tx_empty_event | tx_full_event | rx_full_event;

   // Registered so the request pin never glitches on a level change
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= any_event || rx_wm_match || tx_wm_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial clock divider; held low while the port is off
   always_ff @(posedge clk_sys) begin
      if (!resetn || !port_enable_q) begin
         baud_cnt_q   <= BAUD_ZERO;
         serial_clk_q <= 1'b0;
      end else if (baud_cnt_q >= baud_divider_q) begin
         baud_cnt_q   <= BAUD_ZERO;
         serial_clk_q <= ~serial_clk_q;
      end else begin
         baud_cnt_q   <= baud_cnt_q + 16'h0001;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;
   assign serial_clk      = serial_clk_q;
   assign port_enable     = port_enable_q;
   assign underrun_ignore = underrun_ignore_q;

endmodule

//--- spi_fifo_event_monitor.sv
`timescale 1ns/1ps
module spi_fifo_event_monitor (
   input wire logic                                  clk_sys,
   input wire logic                                  resetn,
   input wire logic [spi_fifo_event_pkg::ADDR_W-1:0] avs_address,
   input wire logic                                  avs_read,
   input wire logic                                  avs_write,
   input wire logic [spi_fifo_event_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [spi_fifo_event_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                                  avs_waitrequest,
   input wire spi_fifo_event_pkg::engine_evt_s       engine_evt,
   input wire logic                                  irq,
   input wire logic                                  serial_clk,
   input wire logic                                  port_enable,
   input wire logic                                  underrun_ignore
);
   import spi_fifo_event_pkg::*;
   logic [15:0] en_q;
   logic [15:0] wm_q;
   logic [15:0] div_q;
   logic [16:0] cnt_q;
   logic        sclk_q;
   logic        fresh_q;
   wire         acc = avs_write && !avs_waitrequest;
   wire         rdv = avs_read && !avs_waitrequest;
   ////////////////////////////////////////
   // Shadow of written settings, seen only through the bus
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         en_q <= 16'h0000;
         wm_q <= 16'h0000;
         div_q <= 16'h0000;
      end else if (acc) begin
         if (avs_address == OFF_EVT_EN) en_q <= avs_writedata[15:0];
         if (avs_address == OFF_WM) wm_q <= avs_writedata[15:0];
         if (avs_address == OFF_BAUD) div_q <= avs_writedata[15:0];
      end
   end
   // A period is judged only after a full one, so divider changes never false-fire
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sclk_q <= 1'b0;
         cnt_q <= 17'h00000;
         fresh_q <= 1'b0;
      end else begin
         sclk_q <= serial_clk;
         cnt_q <= (serial_clk != sclk_q) ? 17'h00001 : cnt_q + 17'h00001;
         if (serial_clk != sclk_q) fresh_q <= 1'b1;
         if (!port_enable || (acc && avs_address == OFF_BAUD)) fresh_q <= 1'b0;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |->
      avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
   AST_UPPER_ZERO: assert property (!avs_waitrequest |->
      avs_readdata[31:16] == 16'h0000) else $error("upper read data not zero");
   AST_LEVEL_GAPS: assert property ((rdv && avs_address == OFF_LEVEL) |->
      (avs_readdata[15:0] & 16'he0e0) == 16'h0000) else $error("absent count bit set");
   AST_EVT_GAPS: assert property ((rdv && avs_address == OFF_EVT_EN) |->
      (avs_readdata[15:0] & ~EVT_EN_MASK) == 16'h0000) else $error("enable gap set");
   AST_WM_GAPS: assert property ((rdv && avs_address == OFF_WM) |->
      (avs_readdata[15:0] & 16'h5050) == 16'h0000) else $error("absent level bit set");
   AST_RESET_OUT: assert property ($rose(resetn) |->
      !irq && avs_waitrequest && !serial_clk && !port_enable) else $error("reset outputs");
   AST_ACTIVITY_IRQ: assert property (
      (en_q[ACTIVITY_BIT] && engine_evt.port_busy) [*3] |-> irq) else $error("busy irq lost");
   AST_MASKED_QUIET: assert property (
      (en_q == 16'h0000 && !wm_q[15] && !wm_q[7]) [*3] |-> !irq) else $error("irq unmasked");
   AST_CLK_IDLE: assert property ((!port_enable) [*2] |-> !serial_clk)
      else $error("serial clock runs while disabled");
   AST_BAUD_PERIOD: assert property ((serial_clk != sclk_q && fresh_q && port_enable) |->
      cnt_q == {1'b0, div_q} + 17'h00001) else $error("serial clock half period wrong");
   cover property (irq ##1 !irq);
   cover property ($rose(serial_clk));
   cover property (rdv && avs_address == OFF_LEVEL && avs_readdata[12]);
endmodule

//--- spi_engine_model.sv
`timescale 1ns/1ps
module spi_engine_model (
   input wire logic                         clk_sys,
   output spi_fifo_event_pkg::engine_evt_s  engine_evt
);
   import spi_fifo_event_pkg::*;
   logic [7:0] evt_q;
   initial evt_q = 8'h00;
   assign engine_evt = evt_q;
   // A gap cycle per word, as a shifter needs at least one clock per word
   task automatic pulse(input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         evt_q[idx] <= 1'b1;
         @(posedge clk_sys);
         evt_q[idx] <= 1'b0;
      end
   endtask
   task automatic level(input int idx, input logic v);
      @(posedge clk_sys);
      evt_q[idx] <= v;
   endtask
endmodule

//--- test_spi_fifo_event_logic.sv
`timescale 1ns/1ps
module test_spi_fifo_event_logic;
   import spi_fifo_event_pkg::*;
   logic                clk_sys;
   logic                resetn = 1'b0;
   logic [ADDR_W-1:0]   avs_address = 8'h00;
   logic                avs_read = 1'b0;
   logic                avs_write = 1'b0;
   logic [DATA_W-1:0]   avs_writedata = 32'h00000000;
   logic [DATA_W-1:0]   avs_readdata;
   logic                avs_waitrequest;
   engine_evt_s         engine_evt;
   logic                irq;
   logic                serial_clk;
   logic                port_enable;
   logic                underrun_ignore;
   int                  err_total = 0;
   int                  checks = 0;
   logic [7:0]          zero_regs[6] = '{OFF_LEVEL, OFF_EVT_EN, OFF_WM, OFF_BAUD, OFF_CTRL, 8'h18};
   spi_fifo_event_logic dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .engine_evt(engine_evt),
      .irq(irq), .serial_clk(serial_clk), .port_enable(port_enable),
      .underrun_ignore(underrun_ignore));
   spi_engine_model eng (.clk_sys(clk_sys), .engine_evt(engine_evt));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task print_verdict;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   // Request held until waitrequest is sampled low; bounded so a dead bus ends the run
   task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= we;
      avs_read <= !we;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_total++;
         print_verdict();
      end
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 16'h0000, r);
      chk(r, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   // irq trails its cause by a flag stage and its own register
   task automatic irq_is(input logic e);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic sweep(input logic [15:0] exp);
      int bits[9] = '{12, 11, 8, 7, 6, 5, 3, 1, 0};
      rd(OFF_FLAGS, {16'h0000, exp});
      foreach (bits[i]) begin
         wr(OFF_EVT_EN, 16'h0001 << bits[i]);
         irq_is(exp[bits[i]]);
      end
      wr(OFF_EVT_EN, 16'h0000);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      foreach (zero_regs[i]) rd(zero_regs[i], 32'h0);
      sweep(16'h0028);
      wr(OFF_EVT_EN, 16'hffff);
      rd(OFF_EVT_EN, {16'h0000, EVT_EN_MASK});
      wr(OFF_WM, 16'hffff);
      rd(OFF_WM, 32'h0000afaf);
      wr(OFF_EVT_EN, 16'h0000);
      wr(OFF_LEVEL, 16'hffff);
      rd(OFF_LEVEL, 32'h0);
      wr(OFF_WM, 16'h0000);
      wr(OFF_BAUD, 16'h0002);
      wr(OFF_CTRL, 16'h0001);
      eng.pulse(7, 3);
      eng.pulse(5, 2);
      rd(OFF_LEVEL, 32'h00000302);
      eng.pulse(7, 14);
      rd(OFF_LEVEL, 32'h00001002);
      wr(OFF_WM, 16'h9000);
      irq_is(1'b1);
      wr(OFF_WM, 16'h9100);
      irq_is(1'b1);
      wr(OFF_WM, 16'ha000);
      irq_is(1'b0);
      wr(OFF_WM, 16'h0082);
      irq_is(1'b1);
      wr(OFF_WM, 16'h0081);
      irq_is(1'b0);
      wr(OFF_WM, 16'h0000);
      eng.pulse(3, 1);
      eng.level(2, 1'b1);
      eng.level(1, 1'b1);
      eng.level(0, 1'b1);
      sweep(16'h19c1);
      wr(OFF_CTRL, 16'h0000);
      rd(OFF_FLAGS, 32'h000018e8);
      eng.level(2, 1'b0);
      eng.level(1, 1'b0);
      eng.level(0, 1'b0);
      wr(OFF_FLAGS, 16'h1140);
      wr(OFF_CTRL, 16'h0003);
      // The control flops load at the accepting edge, so look one edge later
      @(posedge clk_sys);
      chk({30'h0, port_enable, underrun_ignore}, 32'h3);
      eng.pulse(5, 16);
      sweep(16'h0022);
      eng.level(1, 1'b1);
      rd(OFF_FLAGS, 32'h00000122);
      eng.level(1, 1'b0);
      rd(OFF_FLAGS, 32'h00000022);
      repeat (30) @(posedge clk_sys);
      print_verdict();
   end
endmodule
bind spi_fifo_event_logic spi_fifo_event_monitor mon (.clk_sys(clk_sys), .resetn(resetn),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .engine_evt(engine_evt), .irq(irq),
   .serial_clk(serial_clk), .port_enable(port_enable), .underrun_ignore(underrun_ignore));
